// ===== logic/io_block_consts.svh
// Constants for the io_block storage register block
`ifndef IO_BLOCK_CONSTS_SVH
`define IO_BLOCK_CONSTS_SVH

// APB register byte addresses
`define ADDR_POLARITY   12'h000
`define ADDR_TARGET     12'h004
`define ADDR_INITVAL    12'h008
`define ADDR_SRMODE     12'h00c
`define ADDR_MISC       12'h010
`define ADDR_STATE      12'h014

// Field positions in the MISC register
`define MISC_ASYNC_BIT  0
`define MISC_DDR_BIT    1
`define MISC_FWD_BIT    2
`define MISC_INITX_BIT  3
`define MISC_GINIT_BIT  4

// Polarity register bit positions
`define POL_ICE  0
`define POL_OCE  1
`define POL_TCE  2
`define POL_SR   3
`define POL_REV  4

// Element count and reset values
`define ELEM_COUNT      6
`define POLARITY_RESET  5'h00
`define TARGET_RESET    6'h00
`define INITVAL_RESET   6'h00
`define SRMODE_RESET    18'h00000
`define MISC_RESET      5'h08

`endif

// ===== logic/io_block_pkg.sv
// Types for the io_block storage register block
package io_block_pkg;

    // Set/reset option of one storage element
    typedef enum logic [2:0] {
        SR_NONE       = 3'b000,
        SR_SYNC_SET   = 3'b001,
        SR_SYNC_RST   = 3'b010,
        SR_SYNC_BOTH  = 3'b011,
        SR_ASYNC_SET  = 3'b101,
        SR_ASYNC_CLR  = 3'b110,
        SR_ASYNC_BOTH = 3'b111
    } sr_mode_t;

    // Per-element controls
    typedef struct packed {
        logic     targetOne;
        logic     initOne;
        sr_mode_t mode;
    } elem_cfg_t;

    // Raw pin-side controls of the io_block
    typedef struct packed {
        logic inputPairClockEnable;
        logic outputPairClockEnable;
        logic tristatePairClockEnable;
        logic setResetInput;
        logic reverseStateInput;
    } ctrl_pins_t;

endpackage

// ===== logic/io_block_storage_regs.sv
// Io_block input, output and tristate register pairs behind APB
`timescale 1ns/1ps
`include "io_block_consts.svh"

module io_block_storage_regs (
    input  wire logic        ref_clk,     // System clock, 25 MHz
    input  wire logic        rst_n,       // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB enable
    input  wire logic        pwrite,      // APB direction
    input  wire logic [11:0] paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    input  wire io_block_pkg::ctrl_pins_t ctrlPins, // Control pins
    input  wire logic [2:0]  enableConnected, // Enable pin present
    input  wire logic        padIn,       // Pad input level
    input  wire logic [1:0]  outData,     // Output data, rise/fall
    input  wire logic [1:0]  triData,     // Tristate data, rise/fall
    output logic [1:0]       inCapture,   // Captured input pair
    output logic             padOut,      // Pad output value
    output logic             padOe        // Pad output enable
);

    ////////////////////////////////////////////////////////////////////
    // Register file
    logic [4:0]  polarity;
    logic [5:0]  targetOne;
    logic [5:0]  initOne;
    logic [17:0] srMode;
    logic [4:0]  misc;
    logic        initPulse;
    logic        accessDone;

    assign pready     = 1'b1;
    assign accessDone = psel & penable;

    function automatic logic knownAddr(input logic [11:0] a);
        knownAddr = (a == `ADDR_POLARITY) || (a == `ADDR_TARGET) ||
                    (a == `ADDR_INITVAL) || (a == `ADDR_SRMODE) ||
                    (a == `ADDR_MISC) || (a == `ADDR_STATE);
    endfunction

    assign pslverr = accessDone & ~knownAddr(paddr);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            polarity  <= `POLARITY_RESET;
            targetOne <= `TARGET_RESET;
            initOne   <= `INITVAL_RESET;
            srMode    <= `SRMODE_RESET;
            misc      <= `MISC_RESET;
        end else if (accessDone && pwrite) begin
            case (paddr)
                `ADDR_POLARITY: polarity <= pwdata[4:0];
                `ADDR_TARGET: begin
                    targetOne <= pwdata[5:0];
                    if (misc[`MISC_INITX_BIT])
                        initOne <= pwdata[5:0];
                end
                `ADDR_INITVAL: begin
                    initOne <= pwdata[5:0];
                    misc[`MISC_INITX_BIT] <= 1'b0;
                end
                `ADDR_SRMODE: srMode <= pwdata[17:0];
                `ADDR_MISC: misc <= pwdata[4:0];
                default: ;
            endcase
        end
    end

    // One-cycle global initialisation strobe from the MISC write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            initPulse <= 1'b0;
        else
            initPulse <= accessDone & pwrite & (paddr == `ADDR_MISC) &
                         pwdata[`MISC_GINIT_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [5:0] syncA;
    logic [5:0] syncB;
    logic [5:0] rawPins;

    assign rawPins = {padIn, ctrlPins.inputPairClockEnable,
                      ctrlPins.outputPairClockEnable,
                      ctrlPins.tristatePairClockEnable,
                      ctrlPins.setResetInput,
                      ctrlPins.reverseStateInput};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 6'h00;
            syncB <= 6'h00;
        end else begin
            syncA <= rawPins;
            syncB <= syncA;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control polarity and defaults
    logic iceAct;
    logic oceAct;
    logic tceAct;
    logic srAct;
    logic revAct;

    // Enable level after polarity, held active when no pin is fitted
    function automatic logic enableLevel(input logic fitted,
                                         input logic pin,
                                         input logic invert);
        enableLevel = fitted ? (pin ^ invert) : 1'b1;
    endfunction

    // Reverse acts on its own; a collision with set/reset goes to reset unless the element's mode enables set only
    always_comb begin
        iceAct = enableLevel(enableConnected[0], syncB[4],
                             polarity[`POL_ICE]);
        oceAct = enableLevel(enableConnected[1], syncB[3],
                             polarity[`POL_OCE]);
        tceAct = enableLevel(enableConnected[2], syncB[2],
                             polarity[`POL_TCE]);
        srAct  = syncB[1] ^ polarity[`POL_SR];
        revAct = syncB[0] ^ polarity[`POL_REV];
    end

    ////////////////////////////////////////////////////////////////////
    // Storage elements: 0,1 input; 2,3 output; 4,5 tristate
    logic [5:0] q;
    logic [5:0] ce;
    logic [5:0] d;
    logic       ddrMode;
    logic       phase;

    assign ddrMode = misc[`MISC_DDR_BIT];

    // Phase selects rising or falling half of the forwarded clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            phase <= 1'b0;
        else
            phase <= ~phase;
    end

    always_comb begin
        ce[1:0] = {2{iceAct}};
        ce[3:2] = {2{oceAct}};
        ce[5:4] = {2{tceAct}};
        if (ddrMode) begin
            ce[2] = oceAct & ~phase;
            ce[3] = oceAct & phase;
            ce[0] = iceAct & ~phase;
            ce[1] = iceAct & phase;
        end
        d[1:0] = {2{syncB[5]}};
        d[3:2] = misc[`MISC_FWD_BIT] ? 2'b01 : outData;
        d[5:4] = triData;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `ELEM_COUNT; gi++) begin : gElem
            io_storage_elem uElem (
                .clk        (ref_clk),
                .rst_n      (rst_n),
                .initPulse  (initPulse),
                .cfg        ({targetOne[gi], initOne[gi],
                              io_block_pkg::sr_mode_t'(srMode[3*gi +: 3])}),
                .blockAsync (misc[`MISC_ASYNC_BIT]),
                .ce         (ce[gi]),
                .srAct      (srAct),
                .revAct     (revAct),
                .d          (d[gi]),
                .q          (q[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            padOut    <= 1'b0;
            padOe     <= 1'b0;
            inCapture <= 2'b00;
        end else begin
            padOut    <= ddrMode ? (phase ? q[2] : q[3]) : q[2];
            padOe     <= ~(ddrMode ? (phase ? q[4] : q[5]) : q[4]);
            inCapture <= q[1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                `ADDR_POLARITY: prdata <= {27'h0, polarity};
                `ADDR_TARGET:   prdata <= {26'h0, targetOne};
                `ADDR_INITVAL:  prdata <= {26'h0, initOne};
                `ADDR_SRMODE:   prdata <= {14'h0, srMode};
                `ADDR_MISC:     prdata <= {27'h0, misc};
                `ADDR_STATE:    prdata <= {26'h0, q};
                default:        prdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    elem_reset_wins_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (srAct && revAct && !initPulse && srMode[7:6] == 2'b11 &&
         (ce[2] || (srMode[8] && misc[`MISC_ASYNC_BIT]))) |=> !q[2])
        else $error("reset did not win on output element");

    init_load_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        initPulse |=> (q == $past(initOne)))
        else $error("initial value not loaded");

    ce_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!tceAct && !srAct && !revAct && !initPulse) |=> $stable(q[5:4]))
        else $error("tristate pair changed without enable");

    ce_default_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !enableConnected[0] |-> iceAct)
        else $error("unconnected enable not active");

    rev_opposite_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (revAct && !srAct && !initPulse && srMode[1:0] == 2'b11 &&
         (ce[0] || (srMode[2] && misc[`MISC_ASYNC_BIT]))) |=>
        (q[0] == !$past(targetOne[0])))
        else $error("reverse did not force opposite");

    set_target_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (srAct && !revAct && !initPulse && ce[1] &&
         srMode[5:3] == 3'b011 && targetOne[1]) |=> q[1])
        else $error("set target not reached");

    clear_target_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (srAct && !revAct && !initPulse && ce[3] &&
         srMode[10:9] == 2'b11 && !targetOne[3]) |=> !q[3])
        else $error("clear target not reached");

    fwd_high_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (misc[`MISC_FWD_BIT] && ce[2] && !srAct && !revAct &&
         !initPulse) |=> q[2])
        else $error("forwarded clock high half not loaded");

    fwd_low_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (misc[`MISC_FWD_BIT] && ce[3] && !srAct && !revAct &&
         !initPulse) |=> !q[3])
        else $error("forwarded clock low half not loaded");

    init_follow_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (accessDone && pwrite && paddr == `ADDR_TARGET &&
         misc[`MISC_INITX_BIT]) |=> (initOne == $past(pwdata[5:0])))
        else $error("initial value did not follow target");

    async_bypass_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (srAct && !initPulse && misc[`MISC_ASYNC_BIT] &&
         srMode[14:12] == 3'b111 && !targetOne[4]) |=> !q[4])
        else $error("async clear needed the enable");

    sync_gated_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!ce[5] && !initPulse &&
         !(srMode[17] && misc[`MISC_ASYNC_BIT])) |=> $stable(q[5]))
        else $error("element moved without enable");

    ddr_alternate_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ddrMode |=> (padOut == ($past(phase) ? $past(q[2])
                                              : $past(q[3]))))
        else $error("double-rate pin mux wrong");

    polarity_sel_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (enableConnected[1] && !polarity[`POL_OCE]) |->
        (oceAct == syncB[3]))
        else $error("enable polarity wrong");

endmodule // io_block_storage_regs

// ===== logic/io_storage_elem.sv
// One storage element with set/reset, reverse and initial state
`timescale 1ns/1ps
`include "io_block_consts.svh"

module io_storage_elem (
    input  wire logic                 clk,        // Element clock
    input  wire logic                 rst_n,      // Async reset, active low
    input  wire logic                 initPulse,  // Global initialisation
    input  wire io_block_pkg::elem_cfg_t cfg,     // Element controls
    input  wire logic                 blockAsync, // Io_block style
    input  wire logic                 ce,         // Clock enable
    input  wire logic                 srAct,      // Set/reset active
    input  wire logic                 revAct,     // Reverse active
    input  wire logic                 d,          // Data in
    output logic                      q           // Stored value
);

    logic wantSet;
    logic wantRst;
    logic useAsync;

    // Set/reset drives target, reverse drives its opposite
    always_comb begin
        wantSet  = (srAct & cfg.targetOne) | (revAct & ~cfg.targetOne);
        wantRst  = (srAct & ~cfg.targetOne) | (revAct & cfg.targetOne);
        useAsync = blockAsync & cfg.mode[2];
        if (!cfg.mode[0])
            wantSet = 1'b0;
        if (!cfg.mode[1])
            wantRst = 1'b0;
    end

    // Async forms act on the asserted request at the next sample
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (initPulse) begin
            q <= cfg.initOne;
        end else if (wantRst && (useAsync || ce)) begin
            q <= 1'b0;
        end else if (wantSet && (useAsync || ce)) begin
            q <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

endmodule // io_storage_elem

// ===== testbench/io_block_storage_regs_tb.sv
// Self-checking bench for the io_block storage registers
`timescale 1ns/1ps
`include "io_block_consts.svh"

module io_block_storage_regs_tb;
    logic                     ref_clk = 0;
    logic                     rst_n = 0;
    logic                     psel = 0;
    logic                     penable = 0;
    logic                     pwrite = 0;
    logic [11:0]              paddr = 0;
    logic [31:0]              pwdata = 0;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    io_block_pkg::ctrl_pins_t pins = '0;
    logic [2:0]               conn = 3'h7;
    logic                     padIn = 0;
    logic [1:0]               outData = 0;
    logic [1:0]               triData = 0;
    logic [1:0]               inCapture;
    logic                     padOut;
    logic                     padOe;
    int                       badCount = 0;
    int                       checks = 0;
    logic [31:0]              rd;
    logic [31:0]              mdl [6];
    logic                     err, v, s, prev;
    logic [5:0]               st, ex, m, targ;
    logic [2:0]               cd, en3;
    logic [17:0]              mode;
    logic [4:0]               pol;

    io_block_storage_regs dut (
        .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ctrlPins(pins),
        .enableConnected(conn), .padIn, .outData, .triData,
        .inCapture, .padOut, .padOe
    );

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Register write that also updates the bench's copy
    task wreg(input int i, input logic [31:0] val);
        apb(1, 12'(i * 4), val);
        mdl[i] = val & ((i == 0) ? 32'h1f : (i == 3) ? 32'h3ffff : 32'h3f);
    endtask

    // Pin changes pass a 2-stage sync, the element and the pad flop
    task settle_read;
        repeat (4) @(posedge ref_clk);
        apb(0, `ADDR_STATE, 0);
    endtask

    task drv(input logic vv);
        padIn <= vv;
        outData <= {vv, vv};
        triData <= {vv, vv};
    endtask

    task give_verdict;
        $display("Totals: %0d checks, %0d mismatches", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        badCount++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hc62d));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1;
        mdl = '{32'(`POLARITY_RESET), 32'(`TARGET_RESET),
                32'(`INITVAL_RESET), 32'(`SRMODE_RESET), 32'(`MISC_RESET), 0};
        for (int i = 0; i < 6; i++) begin
            apb(0, 12'(i * 4), 0);
            chk(rd, mdl[i]);
        end
        apb(0, 12'h018, 0);
        chk(rd, 0);
        chk(err, 1);
        apb(1, `ADDR_STATE, 32'hffffffff);
        apb(0, `ADDR_STATE, 0);
        chk(rd, 0);
        $display("reset test done");

        // Enables idle: only global initialisation can move the elements
        wreg(1, $urandom);
        apb(1, `ADDR_MISC, 32'h18);
        settle_read();
        chk(rd, mdl[1]);
        wreg(2, $urandom);
        apb(1, `ADDR_MISC, 32'h18);
        settle_read();
        chk(rd, mdl[2]);
        st = mdl[2][5:0];
        for (int i = 0; i < 3; i++) wreg(i, $urandom);
        for (int i = 0; i < 3; i++) begin
            apb(0, 12'(i * 4), 0);
            chk(rd, mdl[i]);
        end
        // Pairs that the random polarity enabled have loaded the idle zeros
        for (int e = 0; e < 6; e++) if (mdl[0][e / 2]) st[e] = 0;
        wreg(0, 0);
        $display("init test done");

        v = 0;
        for (int p = 0; p < 3; p++) begin
            for (int c = 0; c < 3; c++) begin
                v = ~v;
                en3 = 3'h7 & ~(3'h4 >> p);
                pins <= io_block_pkg::ctrl_pins_t'({en3, 2'b00});
                conn <= (c == 2) ? 3'h7 & ~(3'h1 << p) : 3'h7;
                wreg(0, (c == 1) ? 32'h1 << p : 0);
                drv(v);
                for (int e = 0; e < 6; e++) if (e / 2 != p || c != 0) st[e] = v;
                settle_read();
                chk(rd, st);
                chk({inCapture, padOut, padOe}, {st[1:0], st[2], ~st[4]});
            end
        end
        conn <= 3'h7;
        $display("clock enable test done");

        for (int r = 0; r < 8; r++) begin
            s = r[0];
            for (int e = 0; e < 6; e++) begin
                cd = {s, 2'($urandom)};
                if (cd[1:0] == 2'b00) cd = 0;
                targ[e] = (cd[1:0] == 2'b11) ? 1'($urandom) : cd[0];
                mode[3 * e +: 3] = cd;
            end
            pol = {r[2], r[1], 3'b000};
            wreg(0, pol);
            wreg(1, targ);
            wreg(3, mode);
            apb(1, `ADDR_MISC, {28'h0, 3'h4, s});
            apb(0, `ADDR_SRMODE, 0);
            chk(rd, mdl[3]);
            v = 1'($urandom);
            drv(v);
            pins <= io_block_pkg::ctrl_pins_t'({3'h7, pol[3], pol[4]});
            settle_read();
            chk(rd, {26'h0, {6{v}}});
            pins <= io_block_pkg::ctrl_pins_t'({3'h7, ~pol[3], pol[4]});
            for (int e = 0; e < 6; e++) begin
                cd = mode[3 * e +: 3];
                ex[e] = (cd == 0) ? v : targ[e];
                m[e] = (cd[1:0] == 2'b11) ? ~targ[e] : v;
                st[e] = (cd == 0) ? v : (cd[1:0] == 2'b01);
            end
            settle_read();
            chk(rd, ex);
            pins <= io_block_pkg::ctrl_pins_t'({3'h7, pol[3], ~pol[4]});
            settle_read();
            chk(rd, m);
            pins <= io_block_pkg::ctrl_pins_t'({3'h7, ~pol[3], ~pol[4]});
            settle_read();
            chk(rd, st);
            pins <= io_block_pkg::ctrl_pins_t'({3'h7, pol[3], pol[4]});
        end
        $display("set reset test done");

        wreg(0, 0);
        pins <= io_block_pkg::ctrl_pins_t'({3'h7, 2'b00});
        for (int f = 0; f < 2; f++) begin
            apb(1, `ADDR_MISC, f ? 32'he : 32'ha);
            outData <= f ? 2'b00 : 2'b01;
            repeat (5) @(posedge ref_clk);
            prev = padOut;
            repeat (8) begin
                @(posedge ref_clk);
                chk(padOut, !prev);
                prev = padOut;
            end
        end
        $display("double rate test done");
        give_verdict();
    end
endmodule // io_block_storage_regs_tb
